// >>> switch_monitor_pkg.sv
// Constants and types shared by the switch monitor control logic.
package switch_monitor_pkg;
	// ----------------------------------------------------------------
	// Time base and timing counts
	// ----------------------------------------------------------------
	localparam int unsigned REF_CLK_PERIOD_NS  = 40;
	localparam int unsigned TICK_US            = 100;
	localparam int unsigned TICK_CYCLES        = TICK_US * 1000 / REF_CLK_PERIOD_NS;
	localparam int unsigned WET_TIME_MS        = 17;
	localparam int unsigned WET_TICKS          = WET_TIME_MS * 1000 / TICK_US;
	localparam logic [7:0]  WET_LIMIT          = 8'(WET_TICKS);
	localparam int unsigned PERIOD_STEP_US     = 2500;
	localparam int unsigned PERIOD_STEP_TICKS  = PERIOD_STEP_US / TICK_US;
	localparam int unsigned UNIFORM_SCALE      = 4;
	localparam int unsigned STROBE_UNIT_NS     = 1000;
	localparam int unsigned STROBE_UNIT_CYCLES = STROBE_UNIT_NS / REF_CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Switch terminals and supply groups
	// ----------------------------------------------------------------
	localparam int unsigned SW_COUNT  = 10;
	localparam int unsigned GRP_COUNT = 3;
	localparam int unsigned UNIFORM_STEP_TICKS = UNIFORM_SCALE * PERIOD_STEP_TICKS / SW_COUNT;
	localparam logic [9:0]  SW_ALL    = 10'h3ff;
	localparam logic [9:0]  SW_ONE    = 10'h001;
	localparam logic [3:0]  SW_LAST   = 4'h9;
	localparam logic [3:0]  GRP_BASE [GRP_COUNT] = '{4'h0, 4'h4, 4'h7};
	localparam logic [3:0]  GRP_LAST [GRP_COUNT] = '{4'h3, 4'h2, 4'h2};

	// ----------------------------------------------------------------
	// Serial frame layout and command codes
	// ----------------------------------------------------------------
	localparam logic [5:0] FRAME_LEN   = 6'h28;
	localparam logic [5:0] CNT_MAX     = 6'h3f;
	localparam logic [1:0] PREFIX_OK   = 2'h1;
	localparam logic [2:0] SO_HEADER   = 3'h4;
	localparam logic [7:0] CRC_POLY    = 8'h1d;
	localparam logic [7:0] CRC_INIT    = 8'hff;
	localparam logic [7:0] ADDR_NORMAL = 8'h4b;
	localparam logic [7:0] ADDR_SLEEP  = 8'h4c;
	localparam logic [7:0] ADDR_AUTO   = 8'h4e;
	localparam logic [7:0] ADDR_MODE   = 8'h4f;
	localparam logic [7:0] READ_FLAG   = 8'h20;
	localparam logic [7:0] CMD_RESET   = 8'h41;

	// ----------------------------------------------------------------
	// Register fields (positions within the 24-bit data word) and resets
	// ----------------------------------------------------------------
	localparam int unsigned SEQ_LO         = 20;
	localparam int unsigned UNIFORM_BIT    = 21;
	localparam int unsigned PER_SUPPLY_BIT = 20;
	localparam int unsigned INTERMIT_BIT   = 19;
	localparam int unsigned PER_LO [GRP_COUNT] = '{16, 13, 10};
	localparam int unsigned STROBE_LO      = 7;
	localparam int unsigned MODE_BIT       = 23;
	localparam int unsigned AUTO_BIT       = 23;
	localparam logic [23:0] REG_RST        = 24'h000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic test;
		logic therm;
		logic rst;
		logic err;
		logic sw;
	} irq_flags_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic si;
	} link_pins_t;

	localparam irq_flags_t FLAGS_POR = irq_flags_t'(5'h04);
	localparam link_pins_t LINK_IDLE = link_pins_t'(3'h2);

	typedef enum logic [1:0] {
		SCAN_CONT    = 2'b00,
		SCAN_SIMUL   = 2'b01,
		SCAN_GROUP   = 2'b10,
		SCAN_UNIFORM = 2'b11
	} scan_mode_t;
endpackage : switch_monitor_pkg

// >>> switch_monitor_interrupt_mode_ctrl.sv
// Serial link, interrupt causes, operating mode, strobe scheduler and wetting timers.
`timescale 1ns/1ns
`default_nettype none

module switch_monitor_interrupt_mode_ctrl #(
	parameter int unsigned TICK_CYCLES_P = switch_monitor_pkg::TICK_CYCLES
) (
	input  wire logic                                 i_ref_clk,
	input  wire logic                                 i_arst_n,
	input  wire logic                                 i_sclk,
	input  wire logic                                 i_chip_select_n,
	input  wire logic                                 i_si,
	output logic                                      o_so,
	output logic                                      o_so_oe,
	input  wire logic [switch_monitor_pkg::SW_COUNT-1:0] i_switch_level,
	input  wire logic                                 i_test_mode,
	input  wire logic                                 i_thermal_shutdown,
	input  wire logic                                 i_sw_irq_en,
	input  wire logic [switch_monitor_pkg::SW_COUNT-1:0] i_wet_timer_en,
	output logic                                      o_irq_out_n,
	output logic                                      o_irq_out_n_oe,
	output logic                                      o_wake_status_n,
	output logic                                      o_wake_status_n_oe,
	output logic [switch_monitor_pkg::SW_COUNT-1:0]   o_source_en,
	output logic [switch_monitor_pkg::SW_COUNT-1:0]   o_holding_sel,
	output logic                                      o_slope_en
);
	import switch_monitor_pkg::*;

	if (TICK_CYCLES_P < 2 || TICK_CYCLES_P > 65536) begin : g_tick_check
		$error("TICK_CYCLES_P must lie between 2 and 65536");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Accepts a new level only once the second and third stages agree.
	function automatic logic [11:0] settle(input logic [11:0] s2, input logic [11:0] s3,
			input logic [11:0] prev);
		return (s2 & ~(s2 ^ s3)) | (prev & (s2 ^ s3));
	endfunction : settle

	// Eight-bit CRC over the 32 leading frame bits, most significant first.
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 31; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8

	// Period length in ticks for a three-bit period code.
	function automatic logic [7:0] period_len(input logic [2:0] code, input int unsigned step);
		return 8'((int'(code) + 1) * step);
	endfunction : period_len

	// Scan scheme chosen by a mode settings word.
	function automatic scan_mode_t scan_of(input logic [23:0] s);
		if (!s[INTERMIT_BIT])
			return SCAN_CONT;
		if (s[UNIFORM_BIT])
			return SCAN_UNIFORM;
		if (s[PER_SUPPLY_BIT])
			return SCAN_GROUP;
		return SCAN_SIMUL;
	endfunction : scan_of

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	link_pins_t  ls1, ls2, ls3, lf, lf_d;
	logic [11:0] ms1, ms2, ms3, mf, mf_d;
	logic [5:0]  bit_cnt;
	logic [39:0] rx, tx;
	logic [31:0] body;
	irq_flags_t  flags, snap_flags, set_flags, clr_flags;
	logic        readback, read_pending;
	logic [23:0] read_value, normal_set, sleep_set, auto_set, mode_set;
	logic [15:0] tick_cnt;
	logic [7:0]  pcnt [GRP_COUNT];
	logic [7:0]  scnt [GRP_COUNT];
	logic [7:0]  plen [GRP_COUNT];
	logic [9:0]  smask [GRP_COUNT];
	logic [3:0]  ptr [GRP_COUNT];
	logic [3:0]  uptr;
	logic [7:0]  wcnt [SW_COUNT];
	logic [9:0]  sw_state, next_sw, smp, src_on;
	logic [2:0]  fire;
	logic [7:0]  slen, cmd;
	logic [23:0] data, active_set;
	logic        sclk_rise, sclk_fall, cs_fall, cs_rise, frame_ok, tick;
	logic        sleep, sw_changed, test_rise, therm_rise, auto_wake;
	scan_mode_t  scan;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Three stages per pin; the settled copy changes when stages two and three agree.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ls1 <= LINK_IDLE;
			ls2 <= LINK_IDLE;
			ls3 <= LINK_IDLE;
			lf <= LINK_IDLE;
			lf_d <= LINK_IDLE;
			ms1 <= '0;
			ms2 <= '0;
			ms3 <= '0;
			mf <= '0;
			mf_d <= '0;
		end else begin
			ls1 <= {i_sclk, i_chip_select_n, i_si};
			ls2 <= ls1;
			ls3 <= ls2;
			lf <= link_pins_t'(3'(settle({9'h000, ls2}, {9'h000, ls3}, {9'h000, lf})));
			lf_d <= lf;
			ms1 <= {i_test_mode, i_thermal_shutdown, i_switch_level};
			ms2 <= ms1;
			ms3 <= ms2;
			mf <= settle(ms2, ms3, mf);
			mf_d <= mf;
		end
	end

	assign sclk_rise = lf.sclk & ~lf_d.sclk;
	assign sclk_fall = ~lf.sclk & lf_d.sclk;
	assign cs_fall = ~lf.cs_n & lf_d.cs_n;
	assign cs_rise = lf.cs_n & ~lf_d.cs_n;
	assign test_rise = mf[11] & ~mf_d[11];
	assign therm_rise = mf[10] & ~mf_d[10];

	// ----------------------------------------------------------------
	// Serial frame reception and transmission
	// ----------------------------------------------------------------
	// Input bits are taken on clock falls; output bits move on clock rises.
	assign frame_ok = (bit_cnt == FRAME_LEN) && (rx[39:38] == PREFIX_OK)
		&& (crc8(rx[39:8]) == rx[7:0]);
	assign cmd = rx[39:32];
	assign data = rx[31:8];
	assign sleep = mode_set[MODE_BIT];
	assign body = read_pending ? {SO_HEADER, flags, read_value}
		: {SO_HEADER, flags, 1'b0, sleep, 3'h0, sw_state[9:7], 5'h00, sw_state[6:4],
		4'h0, sw_state[3:0]};

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bit_cnt <= 6'h00;
			rx <= '0;
			tx <= '0;
			o_so <= 1'b0;
			o_so_oe <= 1'b0;
			snap_flags <= '0;
			readback <= 1'b0;
		end else begin
			o_so_oe <= ~lf.cs_n;
			if (cs_fall) begin
				bit_cnt <= 6'h00;
				tx <= {body, crc8(body)};
				snap_flags <= read_pending ? irq_flags_t'(5'h00) : flags;
				readback <= read_pending;
			end else if (!lf.cs_n && sclk_fall) begin
				rx <= {rx[38:0], lf.si};
				if (bit_cnt != CNT_MAX)
					bit_cnt <= bit_cnt + 6'h01;
			end
			if (!lf.cs_n && sclk_rise) begin
				o_so <= tx[39];
				tx <= {tx[38:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt causes
	// ----------------------------------------------------------------
	// Only causes shown in the ending frame are cleared; a new set wins.
	always_comb begin
		set_flags.test = test_rise;
		set_flags.therm = therm_rise;
		set_flags.rst = cs_rise && frame_ok && (cmd == CMD_RESET);
		set_flags.err = cs_rise && !frame_ok;
		set_flags.sw = sw_changed;
		clr_flags = cs_rise ? snap_flags : irq_flags_t'(5'h00);
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flags <= FLAGS_POR;
			o_irq_out_n <= 1'b0;
			o_irq_out_n_oe <= 1'b0;
		end else begin
			flags <= (flags & ~clr_flags) | set_flags;
			o_irq_out_n_oe <= |flags;
		end
	end

	// ----------------------------------------------------------------
	// Registers, read-back and operating mode
	// ----------------------------------------------------------------
	// Commands act at the end of a valid frame; a switch change may end sleep.
	assign auto_wake = sleep && auto_set[AUTO_BIT] && i_sw_irq_en && sw_changed;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			normal_set <= REG_RST;
			sleep_set <= REG_RST;
			auto_set <= REG_RST;
			mode_set <= REG_RST;
		end else begin
			if (cs_rise && frame_ok) begin
				case (cmd)
					ADDR_NORMAL: normal_set <= data;
					ADDR_SLEEP: sleep_set <= data;
					ADDR_AUTO: auto_set <= data;
					ADDR_MODE: mode_set <= data;
					CMD_RESET: begin
						normal_set <= REG_RST;
						sleep_set <= REG_RST;
						auto_set <= REG_RST;
						mode_set <= REG_RST;
					end
					default: begin
					end
				endcase
			end
			// A switch change ends sleep even beside another register write; an explicit mode
			// write in the same cycle takes precedence.
			if (auto_wake && !(cs_rise && frame_ok && cmd == ADDR_MODE))
				mode_set[MODE_BIT] <= 1'b0;
		end
	end

	// A read command arms the next frame to return the register value.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			read_pending <= 1'b0;
			read_value <= '0;
		end else if (cs_rise) begin
			read_pending <= frame_ok && ((cmd & READ_FLAG) != 8'h00);
			case (cmd & ~READ_FLAG)
				ADDR_NORMAL: read_value <= normal_set;
				ADDR_SLEEP: read_value <= sleep_set;
				ADDR_AUTO: read_value <= auto_set;
				ADDR_MODE: read_value <= mode_set;
				default: read_value <= '0;
			endcase
		end
	end

	// Wake pin is pulled low in normal mode and released in sleep.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wake_status_n <= 1'b0;
			o_wake_status_n_oe <= 1'b1;
		end else begin
			o_wake_status_n_oe <= ~sleep;
		end
	end

	// ----------------------------------------------------------------
	// Strobe scheduler
	// ----------------------------------------------------------------
	// Periods follow the current mode; strobe length is shared by both.
	assign active_set = sleep ? sleep_set : normal_set;
	assign scan = scan_of(active_set);
	assign slen = 8'((int'(normal_set[STROBE_LO +: 3]) + 1) * STROBE_UNIT_CYCLES);
	assign tick = (tick_cnt == 16'(TICK_CYCLES_P - 1));

	always_comb begin
		smp = '0;
		src_on = '0;
		for (int g = 0; g < GRP_COUNT; g++) begin
			if (scan == SCAN_UNIFORM && g == 0)
				plen[g] = period_len(active_set[PER_LO[g] +: 3], UNIFORM_STEP_TICKS);
			else
				plen[g] = period_len(active_set[PER_LO[g] +: 3], PERIOD_STEP_TICKS);
			fire[g] = tick && (pcnt[g] >= plen[g] - 8'h01);
			src_on = src_on | smask[g];
			if (scnt[g] == 8'h01)
				smp = smp | smask[g];
		end
		if (scan == SCAN_CONT) begin
			smp = SW_ALL;
			src_on = SW_ALL;
		end
		next_sw = (sw_state & ~smp) | (mf[9:0] & smp);
	end

	assign sw_changed = |(next_sw ^ sw_state);

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tick_cnt <= 16'h0000;
			uptr <= 4'h0;
			for (int g = 0; g < GRP_COUNT; g++) begin
				pcnt[g] <= 8'h00;
				scnt[g] <= 8'h00;
				smask[g] <= '0;
				ptr[g] <= 4'h0;
			end
		end else begin
			tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
			for (int g = 0; g < GRP_COUNT; g++) begin
				if (tick)
					pcnt[g] <= fire[g] ? 8'h00 : pcnt[g] + 8'h01;
				if (scnt[g] != 8'h00)
					scnt[g] <= scnt[g] - 8'h01;
				if (scnt[g] == 8'h01)
					smask[g] <= '0;
				if (fire[g]) begin
					case (scan)
						SCAN_SIMUL: begin
							if (g == 0) begin
								smask[g] <= SW_ALL;
								scnt[g] <= slen;
							end
						end
						SCAN_GROUP: begin
							smask[g] <= SW_ONE << (GRP_BASE[g] + ptr[g]);
							scnt[g] <= slen;
							ptr[g] <= (ptr[g] == GRP_LAST[g]) ? 4'h0 : ptr[g] + 4'h1;
						end
						SCAN_UNIFORM: begin
							if (g == 0) begin
								smask[g] <= SW_ONE << uptr;
								scnt[g] <= slen;
								uptr <= (uptr == SW_LAST) ? 4'h0 : uptr + 4'h1;
							end
						end
						default: smask[g] <= '0;
					endcase
				end
			end
		end
	end

	// Sampled switch state and current source drive.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sw_state <= '0;
			o_source_en <= '0;
			o_slope_en <= 1'b0;
		end else begin
			sw_state <= next_sw;
			o_source_en <= src_on;
			o_slope_en <= (scan == SCAN_SIMUL) && (active_set[23:SEQ_LO] == 4'h0);
		end
	end

	// ----------------------------------------------------------------
	// Wetting current timers
	// ----------------------------------------------------------------
	// Counts ticks while a terminal is on, then selects holding current.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_holding_sel <= '0;
			for (int i = 0; i < SW_COUNT; i++)
				wcnt[i] <= 8'h00;
		end else begin
			for (int i = 0; i < SW_COUNT; i++) begin
				if (!i_wet_timer_en[i] || !sw_state[i])
					wcnt[i] <= 8'h00;
				else if (tick && wcnt[i] != WET_LIMIT)
					wcnt[i] <= wcnt[i] + 8'h01;
				o_holding_sel[i] <= i_wet_timer_en[i] && sw_state[i] && (wcnt[i] == WET_LIMIT);
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_irq_pending;
		@(posedge i_ref_clk) disable iff (!i_arst_n) (|flags) |=> o_irq_out_n_oe;
	endproperty
	a_irq_pending: assert property (p_irq_pending) else $error("irq not driven");

	property p_frame_flags;
		@(posedge i_ref_clk) disable iff (!i_arst_n) cs_fall |=> tx[36:32] == $past(flags);
	endproperty
	a_frame_flags: assert property (p_frame_flags) else $error("flags not in frame");

	property p_test_set;
		@(posedge i_ref_clk) disable iff (!i_arst_n) test_rise |=> flags.test;
	endproperty
	a_test_set: assert property (p_test_set) else $error("test cause lost");

	property p_reset_cmd;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
			cs_rise && frame_ok && cmd == CMD_RESET |=> flags.rst && !sleep;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset cause missing");

	property p_err_set;
		@(posedge i_ref_clk) disable iff (!i_arst_n) cs_rise && !frame_ok |=> flags.err;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error cause missing");

	property p_clear;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
			cs_rise && snap_flags.sw && !sw_changed |=> !flags.sw;
	endproperty
	a_clear: assert property (p_clear) else $error("cause not cleared");

	property p_keep_new;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
			cs_rise && flags.test && !snap_flags.test |=> flags.test;
	endproperty
	a_keep_new: assert property (p_keep_new) else $error("new cause cleared");

	property p_readback;
		@(posedge i_ref_clk) disable iff (!i_arst_n) cs_rise && readback && flags.sw |=> flags.sw;
	endproperty
	a_readback: assert property (p_readback) else $error("readback cleared cause");

	property p_wake_pin;
		@(posedge i_ref_clk) disable iff (!i_arst_n) ##1 o_wake_status_n_oe == !$past(sleep);
	endproperty
	a_wake_pin: assert property (p_wake_pin) else $error("wake pin wrong");

	property p_auto_wake;
		@(posedge i_ref_clk) disable iff (!i_arst_n) auto_wake && !cs_rise |=> !sleep;
	endproperty
	a_auto_wake: assert property (p_auto_wake) else $error("no auto wake");

	property p_wet_off;
		@(posedge i_ref_clk) disable iff (!i_arst_n) !sw_state[0] |=> !o_holding_sel[0];
	endproperty
	a_wet_off: assert property (p_wet_off) else $error("holding while off");
endmodule : switch_monitor_interrupt_mode_ctrl

`default_nettype wire

// >>> host_link_model.sv
// Host side of the serial link: frames commands and captures the replies.
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
	input  wire logic i_ref_clk,
	input  wire logic i_so,
	input  wire logic i_so_oe,
	output var logic  o_sclk,
	output var logic  o_chip_select_n,
	output var logic  o_si
);
	// ----------------------------------------------------------------
	// Link driver
	// ----------------------------------------------------------------
	// Between frames the clock stands still and data sits at its pull-down level.
	initial begin
		o_sclk = 1'b0;
		o_chip_select_n = 1'b1;
		o_si = 1'b0;
	end

	// Checksum over the 32 leading bits, most significant bit first.
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 31; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
		end
		return c;
	endfunction : crc8

	// Sends nbits of a frame, MSB first; bad spoils the checksum on purpose.
	task automatic xfer(input logic [31:0] head, input int nbits, input logic bad,
		output logic [39:0] rx);
		logic [39:0] tx;
		tx = {head, crc8(head) ^ {7'h00, bad}};
		rx = 40'h0;
		@(posedge i_ref_clk);
		o_chip_select_n <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		for (int i = 0; i < nbits; i++) begin
			o_si <= tx[39-i];
			o_sclk <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			o_sclk <= 1'b0;
			repeat (4) @(posedge i_ref_clk);
			// The bit moves out a few clocks after the rise; it has settled by now.
			rx[39-i] = i_so_oe ? i_so : ~i_so; // A released line never matches.
		end
		o_chip_select_n <= 1'b1;
		o_si <= 1'b0;
		repeat (16) @(posedge i_ref_clk);
	endtask : xfer
endmodule : host_link_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the switch monitor control block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import switch_monitor_pkg::*;
	// ----------------------------------------------------------------
	// Signals, clock and instances
	// ----------------------------------------------------------------
	logic        ref_clk = 1'b0;
	logic        arst_n, sclk, cs_n, si, so, so_oe, tmode, hot, swen;
	logic        irq, irq_oe, wake, wake_oe, slope, mode_e;
	logic [9:0]  sw, weten, src_en, hold;
	logic [39:0] rx;
	int          fail_count = 0;
	int          check_count = 0;
	int          n, m;

	// Free-running 25 MHz reference clock.
	always #20 ref_clk = ~ref_clk;

	switch_monitor_interrupt_mode_ctrl #(.TICK_CYCLES_P(4)) switch_monitor_interrupt_mode_ctrl_i (
		.i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_sclk(sclk), .i_chip_select_n(cs_n),
		.i_si(si), .o_so(so), .o_so_oe(so_oe), .i_switch_level(sw), .i_test_mode(tmode),
		.i_thermal_shutdown(hot), .i_sw_irq_en(swen), .i_wet_timer_en(weten),
		.o_irq_out_n(irq), .o_irq_out_n_oe(irq_oe), .o_wake_status_n(wake),
		.o_wake_status_n_oe(wake_oe), .o_source_en(src_en), .o_holding_sel(hold),
		.o_slope_en(slope));

	host_link_model host_link_model_i (.i_ref_clk(ref_clk), .i_so(so), .i_so_oe(so_oe),
		.o_sclk(sclk), .o_chip_select_n(cs_n), .o_si(si));

	// ----------------------------------------------------------------
	// Reference model helpers
	// ----------------------------------------------------------------
	// Compares one result and reports a mismatch at once.
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Appends the checksum to an expected reply head.
	function automatic logic [39:0] fr(input logic [31:0] h);
		return {h, host_link_model_i.crc8(h)};
	endfunction : fr

	// Expected status reply for the given pending causes.
	function automatic logic [39:0] stat(input logic [4:0] f);
		return fr({3'h4, f, 1'b0, mode_e, 3'h0, sw[9:7], 5'h00, sw[6:4], 4'h0, sw[3:0]});
	endfunction : stat

	task automatic cmd(input logic [7:0] c, input logic [23:0] d);
		host_link_model_i.xfer({c, d}, 40, 1'b0, rx);
	endtask : cmd

	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : step

	// Flips at least one switch so a change is always seen.
	task automatic flip;
		sw <= sw ^ (10'($urandom) | SW_ONE);
		step(30);
	endtask : flip

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	// Cuts a hang short.
	initial begin
		step(100000);
		fail_count++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(4));
		{sw, weten, tmode, hot, swen, mode_e} = '0;
		arst_n = 1'b0;
		step(5);
		arst_n <= 1'b1;
		step(10);
		chk(40'({irq, irq_oe, wake, wake_oe, src_en}), 40'({3'h2, 1'b1, SW_ALL}));
		cmd(8'h40, 24'h0);
		chk(rx, stat(5'h04));
		chk(40'(irq_oe), 40'h0);
		for (int i = 0; i < 3; i++) begin
			flip();
			chk(40'(irq_oe), 40'h1);
			cmd(8'h40, 24'h0);
			chk(rx, stat(5'h01));
		end
		{tmode, hot} <= 2'h3;
		step(30);
		cmd(8'h40, 24'h0);
		chk(rx, stat(5'h18));
		{tmode, hot} <= 2'h0;
		for (int k = 0; k < 3; k++) begin
			host_link_model_i.xfer(k == 0 ? 32'hc0000000 : 32'h40000000,
				k == 2 ? 39 : 40, k == 1, rx);
			cmd(8'h40, 24'h0);
			chk(rx, stat(5'h02));
		end
		fork
			cmd(8'h40, 24'h0);
			begin
				step(150);
				tmode <= 1'b1;
			end
		join
		chk(40'(irq_oe), 40'h1);
		cmd(8'h40, 24'h0);
		chk(rx, stat(5'h10));
		tmode <= 1'b0;
		cmd(8'h4f, 24'h800000);
		mode_e = 1'b1;
		chk(40'(wake_oe), 40'h0);
		cmd(8'h6f, 24'h0);
		chk(rx, stat(5'h00));
		flip();
		cmd(8'h40, 24'h0);
		chk(rx, fr({3'h4, 5'h01, 24'h800000}));
		chk(40'({irq_oe, wake_oe}), 40'h2);
		cmd(8'h4e, 24'h800000);
		swen <= 1'b1;
		flip();
		chk(40'(wake_oe), 40'h1);
		mode_e = 1'b0;
		cmd(8'h40, 24'h0);
		chk(rx, stat(5'h01));
		cmd(8'h4f, 24'h800000);
		cmd(8'h41, 24'h0);
		chk(40'(wake_oe), 40'h1);
		cmd(8'h40, 24'h0);
		chk(rx, stat(5'h04));
		sw <= '0;
		weten <= SW_ALL;
		step(20);
		sw <= SW_ONE;
		step(500);
		chk(40'(hold), 40'h0);
		step(400);
		chk(40'(hold), 40'(SW_ONE));
		sw <= '0;
		step(30);
		chk(40'(hold), 40'h0);
		// First uniform over per-supply, then per-supply alone; sources must also turn on.
		for (int s = 0; s < 2; s++) begin
			cmd(8'h4b, (s == 0) ? 24'h380000 : 24'h180000);
			n = 0;
			m = 0;
			for (int c = 0; c < 3000; c++) begin
				step(1);
				if (s == 0)
					n += int'($countones(src_en) > 1);
				else
					n += int'($countones(src_en[3:0]) > 1) + int'($countones(src_en[6:4]) > 1)
						+ int'($countones(src_en[9:7]) > 1);
				m += int'(src_en != 10'h000);
			end
			chk(40'({n, m == 0, slope}), 40'h0);
		end
		cmd(8'h4b, 24'h080000);
		chk(40'(slope), 40'h1);
		end_sim();
	end
endmodule : testbench
`default_nettype wire
